/* File: fvpe_avg.sv */
// moving average over a series of phase measurements
`timescale 1ns/100ps
`default_nettype none
module fvpe_avg #(
    parameter int AVG_LOG = fvpe_pkg::AVG_LOG,
    parameter int DW = fvpe_pkg::DW
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // measurement in
    input wire fvpe_pkg::fvpe_meas_s sample,
    // average out
    output logic signed [DW-1:0] avg
);
    localparam int DEPTH = 1 << AVG_LOG;
    localparam int SW = DW + AVG_LOG;

    logic signed [DW-1:0] mem [DEPTH];
    logic signed [DW-1:0] next_mem [DEPTH];
    logic [AVG_LOG-1:0] ptr;
    logic [AVG_LOG-1:0] next_ptr;
    logic signed [SW-1:0] sum;
    logic signed [SW-1:0] next_sum;
    logic signed [DW-1:0] next_avg;

    // running sum: newest in, oldest out
    always_comb begin
        next_mem = mem;
        next_ptr = ptr;
        next_sum = sum;
        if (sample.valid) begin
            next_mem[ptr] = sample.delta;
            next_ptr = ptr + 1'b1;
            next_sum = sum + SW'(sample.delta) - SW'(mem[ptr]);
        end
        next_avg = DW'(next_sum >>> AVG_LOG);
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_mem
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem[g] <= '0;
                end else begin
                    mem[g] <= next_mem[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr <= '0;
            sum <= '0;
            avg <= '0;
        end else begin
            ptr <= next_ptr;
            sum <= next_sum;
            avg <= next_avg;
        end
    end
endmodule
`default_nettype wire

/* File: fvpe_meter.sv */
// energy meter stand-in that counts volume pulses
`timescale 1ns/100ps
`default_nettype none
module fvpe_meter (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pulse line from the sensor
    input wire logic vol_pulse,
    // pulses counted since reset
    output logic [15:0] count
);
    logic prev;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev <= 1'b0;
            count <= 16'h0000;
        end else begin
            prev <= vol_pulse;
            count <= (vol_pulse && !prev) ? count + 16'h0001 : count;
        end
    end
endmodule
`default_nettype wire

/* File: fvpe_pkg.sv */
// constants and carrier types for the flow volume pulse emitter
package fvpe_pkg;
    localparam int CLK_MHZ = 125;
    localparam int SEC_US = 1000000;
    localparam int SEC_CYC = SEC_US * CLK_MHZ;
    localparam int CARRIER_MHZ = 1;
    localparam int CARRIER_CYC = CLK_MHZ / CARRIER_MHZ;
    localparam int PULSE_HIGH_US = 2000;
    localparam int PULSE_HIGH_CYC = (PULSE_HIGH_US * CLK_MHZ + 0) / 1;
    localparam int PULSE_GAP_US = 2000;
    localparam int PULSE_GAP_CYC = PULSE_GAP_US * CLK_MHZ;
    localparam int BURST_PAUSE_US = 30000;
    localparam int BURST_PAUSE_CYC = BURST_PAUSE_US * CLK_MHZ;
    localparam int BURST_LEN = 10;
    localparam int MAX_PULSES = 125;
    localparam int SETTLE_S = 16;
    localparam int STRAP_S = 1;
    localparam int MEAS_NORM_PER_S = 8;
    localparam int TEST_DIV = 4;
    localparam int MEAS_QTR_CYC = SEC_CYC / (MEAS_NORM_PER_S * TEST_DIV);
    localparam int FRAC = 8;
    localparam int SHIFT_NORM = 3;
    localparam int SHIFT_TEST = 5;
    localparam int AVG_LOG = 6;
    localparam int DW = 8;
    localparam logic [7:0] PH_WRAP = 8'h7d;
    localparam logic [7:0] PH_HALF = 8'h3f;
    localparam logic [7:0] PH_MAX = 8'hff;
    localparam logic [31:0] SAT_Q = 32'h00007d00;

    typedef struct packed {
        logic valid;
        logic signed [DW-1:0] delta;
    } fvpe_meas_s;

    typedef enum logic [1:0] {
        EM_IDLE = 2'b00,
        EM_HIGH = 2'b01,
        EM_GAP = 2'b10,
        EM_PAUSE = 2'b11
    } fvpe_em_e;
endpackage

/* File: fvpe_tb_top.sv */
// self-checking bench for the flow volume pulse emitter
`timescale 1ns/100ps
`default_nettype none
module fvpe_tb_top;
    localparam int SEC = 3200;
    // a second's pulses, up to the saturated count, are all out by this many cycles
    localparam int DONE = 2900;
    typedef struct packed {
        logic [7:0] ph;
        logic [15:0] n;
    } fvpe_row_s;
    // phase delay in clocks and pulses per second, gain three per count
    fvpe_row_s rows [0:2] = '{'{8'h0a, 16'h001e}, '{8'h32, 16'h007d}, '{8'h5a, 16'h0000}};
    logic clk = 1'b0;
    logic resetn, rx_up, rx_down, test_strap_n, vol_pulse, test_mode, settled;
    logic [7:0] ph;
    logic [7:0] m = 8'h00;
    logic [15:0] count, st, tail;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;

    fvpe_top #(
        .SEC_CYC(SEC), .MEAS_QTR_CYC(SEC / 32), .PULSE_HIGH_CYC(10), .PULSE_GAP_CYC(10),
        .BURST_PAUSE_CYC(40), .GAIN(16'h0300), .CUTOFF(8'sh01)
    ) dut (
        .clk(clk), .resetn(resetn), .rx_up(rx_up), .rx_down(rx_down),
        .test_strap_n(test_strap_n), .vol_pulse(vol_pulse), .test_mode(test_mode),
        .settled(settled)
    );
    fvpe_meter meter (.clk(clk), .resetn(resetn), .vol_pulse(vol_pulse), .count(count));

    initial begin
        forever #4 clk = ~clk;
    end

    // two 1 MHz carriers, downstream lagging by ph clocks
    always @(posedge clk) begin
        m <= (m == 8'h7c) ? 8'h00 : m + 8'h01;
        rx_up <= m < 8'h3e;
        rx_down <= ((m >= ph) ? m - ph : m + 8'h7d - ph) < 8'h3e;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // the run needs about 81000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        resetn <= 1'b0;
        test_strap_n <= 1'b0;
        ph = rows[0].ph;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int n = 0; n < 70000 && settled !== 1'b1; n++) begin
            wait_cyc(1);
        end
        check({15'h0000, test_mode}, 16'h0001);
        check(count, 16'h0000);
        // a row's phase is set just after a tick; its count is loaded three ticks later
        for (int i = 0; i < 3; i++) begin
            if (i > 0) begin
                tail = count;
                wait_cyc(SEC);
                check({15'h0000, count != tail}, 16'h0001);
                wait_cyc(2 * SEC - DONE - 1);
            end else begin
                wait_cyc(SEC - 1);
            end
            st = count;
            wait_cyc(1);
            if (i < 2) begin
                ph = rows[i + 1].ph;
            end
            wait_cyc(DONE);
            check(count - st, rows[i].n);
        end
        // second reset with the strap open stays in normal mode
        @(posedge clk);
        resetn <= 1'b0;
        test_strap_n <= 1'b1;
        wait_cyc(2);
        check({13'h0000, vol_pulse, test_mode, settled}, 16'h0000);
        @(posedge clk);
        resetn <= 1'b1;
        wait_cyc(SEC + SEC / 4);
        check({13'h0000, vol_pulse, test_mode, settled}, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire

/* File: fvpe_top.sv */
// flow measurement, volume accumulation and burst pulse emission
`timescale 1ns/100ps
`default_nettype none
module fvpe_top #(
    parameter int SEC_CYC = fvpe_pkg::SEC_CYC,
    parameter int MEAS_QTR_CYC = fvpe_pkg::MEAS_QTR_CYC,
    parameter int PULSE_HIGH_CYC = fvpe_pkg::PULSE_HIGH_CYC,
    parameter int PULSE_GAP_CYC = fvpe_pkg::PULSE_GAP_CYC,
    parameter int BURST_PAUSE_CYC = fvpe_pkg::BURST_PAUSE_CYC,
    parameter logic [15:0] GAIN = 16'h0100,
    parameter logic signed [7:0] CUTOFF = 8'sh01
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // received transducer signals
    input wire logic rx_up,
    input wire logic rx_down,
    // test strap, low selects test mode
    input wire logic test_strap_n,
    // outputs
    output logic vol_pulse,
    output logic test_mode,
    output logic settled
);
    // input synchronisers
    logic [2:0] up_sync;
    logic [2:0] dn_sync;
    logic [2:0] st_sync;
    logic up_lvl;
    logic dn_lvl;
    logic st_lvl;
    logic up_old;
    logic dn_old;
    logic next_up_lvl;
    logic next_dn_lvl;
    logic next_st_lvl;

    always_comb begin
        next_up_lvl = (up_sync[1] == up_sync[2]) ? up_sync[2] : up_lvl;
        next_dn_lvl = (dn_sync[1] == dn_sync[2]) ? dn_sync[2] : dn_lvl;
        next_st_lvl = (st_sync[1] == st_sync[2]) ? st_sync[2] : st_lvl;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up_sync <= '0;
            dn_sync <= '0;
            st_sync <= 3'h7;
            up_lvl <= 1'b0;
            dn_lvl <= 1'b0;
            st_lvl <= 1'b1;
            up_old <= 1'b0;
            dn_old <= 1'b0;
        end else begin
            up_sync <= {up_sync[1:0], rx_up};
            dn_sync <= {dn_sync[1:0], rx_down};
            st_sync <= {st_sync[1:0], test_strap_n};
            up_lvl <= next_up_lvl;
            dn_lvl <= next_dn_lvl;
            st_lvl <= next_st_lvl;
            up_old <= up_lvl;
            dn_old <= dn_lvl;
        end
    end

    wire up_rise = up_lvl & ~up_old;
    wire dn_rise = dn_lvl & ~dn_old;

    // phase counter between carrier edges
    logic [7:0] ph_cnt;
    logic [7:0] next_ph_cnt;
    logic signed [7:0] phase;
    logic signed [7:0] next_phase;

    function automatic logic signed [7:0] fold_phase(input logic [7:0] cnt);
        if (cnt >= fvpe_pkg::PH_WRAP) begin
            fold_phase = 8'sh00;
        end else if (cnt > fvpe_pkg::PH_HALF) begin
            fold_phase = $signed(cnt - fvpe_pkg::PH_WRAP);
        end else begin
            fold_phase = $signed(cnt);
        end
    endfunction

    always_comb begin
        next_ph_cnt = (ph_cnt == fvpe_pkg::PH_MAX) ? ph_cnt : ph_cnt + 8'h01;
        next_phase = phase;
        if (up_rise) begin
            next_ph_cnt = 8'h01; // rise cycle counts, so a lag of n clocks reads n
        end
        if (dn_rise) begin
            next_phase = fold_phase(ph_cnt);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_cnt <= fvpe_pkg::PH_MAX;
            phase <= '0;
        end else begin
            ph_cnt <= next_ph_cnt;
            phase <= next_phase;
        end
    end

    // timebase: seconds and quarter measurement ticks
    logic [31:0] sec_cnt;
    logic [31:0] qtr_cnt;
    logic [1:0] qtr_div;
    logic [4:0] sec_num;
    logic strap_done;
    logic [31:0] next_sec_cnt;
    logic [31:0] next_qtr_cnt;
    logic [1:0] next_qtr_div;
    logic [4:0] next_sec_num;
    logic next_test_mode;
    logic next_strap_done;
    logic next_settled;
    logic sec_tick;
    logic meas_tick;

    always_comb begin
        sec_tick = (sec_cnt == 32'(SEC_CYC - 1));
        next_sec_cnt = sec_tick ? 32'h0 : sec_cnt + 32'h1;
        next_qtr_cnt = (qtr_cnt == 32'(MEAS_QTR_CYC - 1)) ? 32'h0 : qtr_cnt + 32'h1;
        next_qtr_div = qtr_div;
        meas_tick = 1'b0;
        if (qtr_cnt == 32'(MEAS_QTR_CYC - 1)) begin
            next_qtr_div = qtr_div + 2'h1;
            meas_tick = test_mode || (qtr_div == 2'(fvpe_pkg::TEST_DIV - 1));
        end
        next_sec_num = sec_num;
        next_test_mode = test_mode;
        next_strap_done = strap_done;
        next_settled = settled;
        if (sec_tick) begin
            if (sec_num != 5'(fvpe_pkg::SETTLE_S)) begin
                next_sec_num = sec_num + 5'h1;
            end
            if (!strap_done && (sec_num == 5'(fvpe_pkg::STRAP_S - 1))) begin
                next_test_mode = ~st_lvl;
                next_strap_done = 1'b1;
            end
            if (sec_num == 5'(fvpe_pkg::SETTLE_S - 1)) begin
                next_settled = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sec_cnt <= '0;
            qtr_cnt <= '0;
            qtr_div <= '0;
            sec_num <= '0;
            test_mode <= 1'b0;
            strap_done <= 1'b0;
            settled <= 1'b0;
        end else begin
            sec_cnt <= next_sec_cnt;
            qtr_cnt <= next_qtr_cnt;
            qtr_div <= next_qtr_div;
            sec_num <= next_sec_num;
            test_mode <= next_test_mode;
            strap_done <= next_strap_done;
            settled <= next_settled;
        end
    end

    // averaging of measurements
    fvpe_pkg::fvpe_meas_s meas;
    logic signed [7:0] avg;

    always_comb begin
        meas.valid = meas_tick;
        meas.delta = phase;
    end

    fvpe_avg #(
        .AVG_LOG(fvpe_pkg::AVG_LOG),
        .DW(fvpe_pkg::DW)
    ) u_avg (
        .clk(clk),
        .resetn(resetn),
        .sample(meas),
        .avg(avg)
    );

    // flow in pulses per second with fraction, and volume accumulation
    logic [31:0] flow_q;
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [31:0] acc_sum;
    logic [31:0] whole;
    logic [6:0] owed;
    logic [6:0] next_owed;
    logic signed [24:0] prod;

    always_comb begin
        prod = avg * $signed({1'b0, GAIN});
        if (avg < CUTOFF) begin
            flow_q = 32'h0;
        end else if (32'(prod) > fvpe_pkg::SAT_Q) begin
            flow_q = fvpe_pkg::SAT_Q;
        end else begin
            flow_q = 32'(prod);
        end
        acc_sum = acc;
        if (meas_tick) begin
            acc_sum = acc + (flow_q >> (test_mode ? fvpe_pkg::SHIFT_TEST
                                                   : fvpe_pkg::SHIFT_NORM));
        end
        next_acc = acc_sum;
        next_owed = owed;
        whole = acc_sum >> fvpe_pkg::FRAC;
        if (sec_tick) begin
            if (whole >= 32'(fvpe_pkg::MAX_PULSES)) begin
                next_owed = 7'(fvpe_pkg::MAX_PULSES);
                next_acc = acc_sum & 32'(((1 << fvpe_pkg::FRAC) - 1));
            end else begin
                next_owed = whole[6:0];
                next_acc = acc_sum - (whole << fvpe_pkg::FRAC);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc <= '0;
            owed <= '0;
        end else begin
            acc <= next_acc;
            owed <= next_owed;
        end
    end

    // burst emitter
    fvpe_pkg::fvpe_em_e em_state;
    fvpe_pkg::fvpe_em_e next_em_state;
    logic [31:0] em_tmr;
    logic [31:0] next_em_tmr;
    logic [6:0] left;
    logic [6:0] next_left;
    logic [3:0] in_burst;
    logic [3:0] next_in_burst;
    logic load;
    logic next_vol_pulse;

    always_comb begin
        next_em_state = em_state;
        next_em_tmr = em_tmr - 32'h1;
        next_left = left;
        next_in_burst = in_burst;
        load = sec_tick && settled && (next_owed != 7'h0);
        case (em_state)
            fvpe_pkg::EM_IDLE: begin
                next_em_tmr = 32'h0;
            end
            fvpe_pkg::EM_HIGH: begin
                if (em_tmr == 32'h0) begin
                    next_left = left - 7'h1;
                    next_in_burst = in_burst + 4'h1;
                    if (left == 7'h1) begin
                        next_em_state = fvpe_pkg::EM_IDLE;
                    end else if (in_burst == 4'(fvpe_pkg::BURST_LEN - 1)) begin
                        next_em_state = fvpe_pkg::EM_PAUSE;
                        next_em_tmr = 32'(BURST_PAUSE_CYC - 1);
                        next_in_burst = 4'h0;
                    end else begin
                        next_em_state = fvpe_pkg::EM_GAP;
                        next_em_tmr = 32'(PULSE_GAP_CYC - 1);
                    end
                end
            end
            fvpe_pkg::EM_GAP, fvpe_pkg::EM_PAUSE: begin
                if (em_tmr == 32'h0) begin
                    next_em_state = fvpe_pkg::EM_HIGH;
                    next_em_tmr = 32'(PULSE_HIGH_CYC - 1);
                end
            end
            default: begin
                next_em_state = fvpe_pkg::EM_IDLE;
            end
        endcase
        if (load) begin
            next_em_state = fvpe_pkg::EM_HIGH;
            next_em_tmr = 32'(PULSE_HIGH_CYC - 1);
            next_left = next_owed;
            next_in_burst = 4'h0;
        end
        next_vol_pulse = (next_em_state == fvpe_pkg::EM_HIGH);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            em_state <= fvpe_pkg::EM_IDLE;
            em_tmr <= '0;
            left <= '0;
            in_burst <= '0;
            vol_pulse <= 1'b0;
        end else begin
            em_state <= next_em_state;
            em_tmr <= next_em_tmr;
            left <= next_left;
            in_burst <= next_in_burst;
            vol_pulse <= next_vol_pulse;
        end
    end
endmodule
`default_nettype wire

/* File: fvpe_top_sva.sv */
// assertion checker for the flow volume pulse emitter
`timescale 1ns/100ps
`default_nettype none
module fvpe_top_sva #(
    parameter int SEC_CYC = fvpe_pkg::SEC_CYC,
    parameter int PULSE_HIGH_CYC = fvpe_pkg::PULSE_HIGH_CYC,
    parameter int PULSE_GAP_CYC = fvpe_pkg::PULSE_GAP_CYC,
    parameter int BURST_PAUSE_CYC = fvpe_pkg::BURST_PAUSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // strap
    input wire logic test_strap_n,
    // outputs watched
    input wire logic vol_pulse,
    input wire logic test_mode,
    input wire logic settled
);
    logic [31:0] hi_cnt, lo_cnt, burst_cnt, run_cnt, up_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt <= 32'h0;
            lo_cnt <= 32'h0;
            burst_cnt <= 32'h0;
            run_cnt <= 32'h0;
            up_cnt <= 32'h0;
        end else begin
            hi_cnt <= vol_pulse ? hi_cnt + 32'h1 : 32'h0;
            lo_cnt <= vol_pulse ? 32'h0 : lo_cnt + 32'h1;
            up_cnt <= up_cnt + 32'h1;
            if (vol_pulse && lo_cnt != 32'h0) begin
                burst_cnt <= (lo_cnt == PULSE_GAP_CYC) ? burst_cnt + 32'h1 : 32'h1;
                run_cnt <= (lo_cnt > 2 * BURST_PAUSE_CYC) ? 32'h1 : run_cnt + 32'h1;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    pulse_width_a: assert property ($fell(vol_pulse) |-> hi_cnt == PULSE_HIGH_CYC)
        else $error("pulse width wrong");
    pulse_cap_a: assert property (vol_pulse |-> hi_cnt < PULSE_HIGH_CYC)
        else $error("pulse too long");
    burst_len_a: assert property ($rose(vol_pulse) && lo_cnt == PULSE_GAP_CYC
        |-> burst_cnt < 32'ha)
        else $error("burst too long");
    pause_len_a: assert property ($rose(vol_pulse) && lo_cnt != PULSE_GAP_CYC
        |-> lo_cnt == BURST_PAUSE_CYC || lo_cnt > 2 * BURST_PAUSE_CYC)
        else $error("burst pause wrong");
    pause_full_a: assert property ($rose(vol_pulse) && lo_cnt == BURST_PAUSE_CYC
        |-> burst_cnt == 32'ha)
        else $error("pause after short burst");
    max_rate_a: assert property ($rose(vol_pulse) && lo_cnt <= 2 * BURST_PAUSE_CYC
        |-> run_cnt < 32'h7d)
        else $error("too many pulses");
    quiet_early_a: assert property (!settled |-> !vol_pulse)
        else $error("pulse before settled");
    settle_time_a: assert property ($rose(settled)
        |-> up_cnt >= 16 * SEC_CYC - 3 && up_cnt <= 16 * SEC_CYC + 3)
        else $error("settle time wrong");
    mode_time_a: assert property ($rose(test_mode) |-> !$past(test_strap_n)
        && up_cnt >= SEC_CYC - 3 && up_cnt <= SEC_CYC + 3)
        else $error("test mode entry wrong");
    state_hold_a: assert property (!$fell(settled) && !$fell(test_mode))
        else $error("state flag dropped");
endmodule
bind fvpe_top fvpe_top_sva #(
    .SEC_CYC(SEC_CYC),
    .PULSE_HIGH_CYC(PULSE_HIGH_CYC),
    .PULSE_GAP_CYC(PULSE_GAP_CYC),
    .BURST_PAUSE_CYC(BURST_PAUSE_CYC)
) chk (
    .clk(clk),
    .resetn(resetn),
    .test_strap_n(test_strap_n),
    .vol_pulse(vol_pulse),
    .test_mode(test_mode),
    .settled(settled)
);
`default_nettype wire
